// *** common/gpxi_pkg.sv ***
package gpxi_pkg;

	// ----------------------------------------
	// port geometry
	// ----------------------------------------
	localparam int unsigned PIN_COUNT = 8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_DIR   = 8'h00;
	localparam logic [7:0] RST_OPT   = 8'h00;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [1:0] RST_SENS  = 2'h0;

	// ----------------------------------------
	// sensitivity encodings of ext_irq_edge_select
	// ----------------------------------------
	localparam logic [1:0] SENS_FALL_LOW = 2'h0;
	localparam logic [1:0] SENS_RISE     = 2'h1;
	localparam logic [1:0] SENS_FALL     = 2'h2;
	localparam logic [1:0] SENS_BOTH     = 2'h3;

	// ----------------------------------------
	// cpu-side access and peripheral carriers
	// ----------------------------------------
	typedef struct packed {
		logic       wr_latch;
		logic       wr_dir;
		logic       wr_opt;
		logic       wr_sens;
		logic [7:0] wdata;
		logic [1:0] wsens;
	} gpxi_cpu_t;

	typedef struct packed {
		logic [7:0] out_en;
		logic [7:0] out_val;
		logic [7:0] open_drain;
		logic [7:0] in_en;
	} gpxi_alt_t;

endpackage

// *** design/gpxi_detect.sv ***
`timescale 1ns/1ns
module gpxi_detect (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// pin and sensitivity
	input  wire logic       level,
	input  wire logic       enable,
	input  wire logic [1:0] sens,
	output logic            event_out
);

	logic prev;
	logic next_prev;

	always_comb begin
		next_prev = level;
		event_out = 1'b0;
		if (enable) begin
			unique case (sens)
				gpxi_pkg::SENS_FALL_LOW: event_out = ~level;
				gpxi_pkg::SENS_RISE:     event_out = level & ~prev;
				gpxi_pkg::SENS_FALL:     event_out = ~level & prev;
				gpxi_pkg::SENS_BOTH:     event_out = level ^ prev;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prev <= 1'b0;
		end else begin
			prev <= next_prev;
		end
	end

endmodule

// *** design/gpxi_port.sv ***
`timescale 1ns/1ns
module gpxi_port (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// cpu access
	input  wire gpxi_pkg::gpxi_cpu_t cpu,
	input  wire logic                vector_fetch,
	output logic [7:0]               latch_rdata,
	output logic [7:0]               dir_rdata,
	output logic [7:0]               opt_rdata,
	output logic [1:0]               sens_rdata,
	output logic                     irq_req,
	// alternate functions
	input  wire gpxi_pkg::gpxi_alt_t alt,
	output logic [7:0]               alt_in,
	// pins
	input  wire logic [7:0]          pin_in,
	output logic [7:0]               pin_out,
	output logic [7:0]               pin_oe
);

	localparam int unsigned N = gpxi_pkg::PIN_COUNT;

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic [N-1:0] pin_data_latch;
	logic [N-1:0] dir;
	logic [N-1:0] opt;
	logic [1:0]   ext_irq_edge_select;
	logic [N-1:0] next_latch;
	logic [N-1:0] next_dir;
	logic [N-1:0] next_opt;
	logic [1:0]   next_sens;

	always_comb begin
		next_latch = cpu.wr_latch ? cpu.wdata : pin_data_latch;
		next_dir   = cpu.wr_dir ? cpu.wdata : dir;
		next_opt   = cpu.wr_opt ? cpu.wdata : opt;
		next_sens  = cpu.wr_sens ? cpu.wsens : ext_irq_edge_select;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_data_latch      <= gpxi_pkg::RST_LATCH;
			dir                 <= gpxi_pkg::RST_DIR;
			opt                 <= gpxi_pkg::RST_OPT;
			ext_irq_edge_select <= gpxi_pkg::RST_SENS;
		end else begin
			pin_data_latch      <= next_latch;
			dir                 <= next_dir;
			opt                 <= next_opt;
			ext_irq_edge_select <= next_sens;
		end
	end

	// ----------------------------------------
	// pin synchronisers and detectors
	// ----------------------------------------
	logic [N-1:0] pin_sync;
	logic [N-1:0] det;

	for (genvar i = 0; i < N; i++) begin : g_pin
		gpxi_sync u_sync (
			.clk      (clk),
			.reset    (reset),
			.async_in (pin_in[i]),
			.sync_out (pin_sync[i])
		);
		gpxi_detect u_det (
			.clk       (clk),
			.reset     (reset),
			.level     (pin_sync[i]),
			.enable    (~dir[i] & opt[i] & ~alt.out_en[i]),
			.sens      (ext_irq_edge_select),
			.event_out (det[i])
		);
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	logic [N-1:0] drv_val;
	logic [N-1:0] drv_od;
	logic [N-1:0] drv_en;
	logic [N-1:0] next_pin_out;
	logic [N-1:0] next_pin_oe;

	always_comb begin
		drv_en  = alt.out_en | dir;
		drv_val = (alt.out_en & alt.out_val) | (~alt.out_en & pin_data_latch);
		drv_od  = (alt.out_en & alt.open_drain) | (~alt.out_en & opt);
		next_pin_oe  = drv_en & ~(drv_od & drv_val);
		next_pin_out = drv_val & ~drv_od;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_out <= 8'h00;
			pin_oe  <= 8'h00;
		end else begin
			pin_out <= next_pin_out;
			pin_oe  <= next_pin_oe;
		end
	end

	// ----------------------------------------
	// read-back and alternate input
	// ----------------------------------------
	logic [N-1:0] next_rdata;
	logic [N-1:0] next_alt_in;

	always_comb begin
		next_rdata = (dir & pin_data_latch)
			| (~dir & alt.out_en & alt.out_val)
			| (~dir & ~alt.out_en & pin_sync);
		next_alt_in = (dir & pin_data_latch) | (~dir & pin_sync);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			latch_rdata <= 8'h00;
			alt_in      <= 8'h00;
		end else begin
			latch_rdata <= next_rdata;
			alt_in      <= next_alt_in;
		end
	end

	assign dir_rdata  = dir;
	assign opt_rdata  = opt;
	assign sens_rdata = ext_irq_edge_select;

	// ----------------------------------------
	// interrupt request latch
	// ----------------------------------------
	logic any_event;
	logic next_irq;

	always_comb begin
		any_event = |det;
		next_irq  = irq_req;
		if (vector_fetch || cpu.wr_sens) begin
			next_irq = 1'b0;
		end
		if (any_event && !cpu.wr_sens) begin
			next_irq = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= next_irq;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_latch_write: assert property (@(posedge clk) disable iff (reset)
		cpu.wr_latch |=> pin_data_latch == $past(cpu.wdata))
		else $error("latch write lost");

	chk_out_read: assert property (@(posedge clk) disable iff (reset)
		(dir[0] && !cpu.wr_latch && !cpu.wr_dir) |=>
		latch_rdata[0] == $past(pin_data_latch[0]))
		else $error("output read not latch");

	chk_in_read: assert property (@(posedge clk) disable iff (reset)
		(!dir[1] && !alt.out_en[1]) |=> latch_rdata[1] == $past(pin_sync[1]))
		else $error("input read not pin");

	chk_od_float: assert property (@(posedge clk) disable iff (reset)
		(dir[2] && opt[2] && pin_data_latch[2] && !alt.out_en[2])
		|=> !pin_oe[2])
		else $error("open drain drives high");

	chk_drive_low: assert property (@(posedge clk) disable iff (reset)
		(dir[3] && !pin_data_latch[3] && !alt.out_en[3])
		|=> pin_oe[3] && !pin_out[3])
		else $error("low not driven");

	chk_input_hiz: assert property (@(posedge clk) disable iff (reset)
		(!dir[4] && !alt.out_en[4]) |=> !pin_oe[4])
		else $error("input pin driven");

	chk_alt_drive: assert property (@(posedge clk) disable iff (reset)
		(alt.out_en[5] && !alt.open_drain[5]) |=>
		pin_oe[5] && pin_out[5] == $past(alt.out_val[5]))
		else $error("alternate output not driven");

	chk_alt_read: assert property (@(posedge clk) disable iff (reset)
		(!dir[6] && alt.out_en[6]) |=> latch_rdata[6] == $past(alt.out_val[6]))
		else $error("alternate status not read");

	chk_irq_set: assert property (@(posedge clk) disable iff (reset)
		(any_event && !cpu.wr_sens) |=> irq_req)
		else $error("event not latched");

	chk_irq_clear: assert property (@(posedge clk) disable iff (reset)
		(cpu.wr_sens || (vector_fetch && !any_event)) |=> !irq_req)
		else $error("request not cleared");

	chk_reset_cfg: assert property (@(posedge clk)
		reset |=> dir == 8'h00 && opt == 8'h00 && !irq_req)
		else $error("reset did not clear");

	chk_dir_write: assert property (@(posedge clk) disable iff (reset)
		cpu.wr_dir |=> dir == $past(cpu.wdata))
		else $error("direction write lost");

	chk_opt_write: assert property (@(posedge clk) disable iff (reset)
		cpu.wr_opt |=> opt == $past(cpu.wdata))
		else $error("option write lost");

	chk_sens_write: assert property (@(posedge clk) disable iff (reset)
		cpu.wr_sens |=> ext_irq_edge_select == $past(cpu.wsens))
		else $error("sensitivity write lost");

	chk_plain_quiet: assert property (@(posedge clk) disable iff (reset)
		(det & (dir | ~opt | alt.out_en)) == 8'h00)
		else $error("event on non interrupt pin");

	chk_irq_hold: assert property (@(posedge clk) disable iff (reset)
		(irq_req && !vector_fetch && !cpu.wr_sens) |=> irq_req)
		else $error("request lost without clear");

	chk_rise_event: assert property (@(posedge clk) disable iff (reset)
		(ext_irq_edge_select == gpxi_pkg::SENS_RISE && opt[3] && !dir[3]
		&& !alt.out_en[3] && $rose(pin_sync[3]) && !cpu.wr_sens)
		|=> irq_req)
		else $error("rising edge not latched");

	chk_alt_override: assert property (@(posedge clk) disable iff (reset)
		(dir[7] && alt.out_en[7] && !alt.open_drain[7]) |=>
		pin_oe[7] && pin_out[7] == $past(alt.out_val[7]))
		else $error("alternate did not override");

	chk_od_alt: assert property (@(posedge clk) disable iff (reset)
		(alt.out_en[6] && alt.open_drain[6] && alt.out_val[6]) |=> !pin_oe[6])
		else $error("alternate open drain drives high");

	chk_alt_in_latch: assert property (@(posedge clk) disable iff (reset)
		dir[4] |=> alt_in[4] == $past(pin_data_latch[4]))
		else $error("alternate input not latch");

	chk_alt_in_pin: assert property (@(posedge clk) disable iff (reset)
		!dir[3] |=> alt_in[3] == $past(pin_sync[3]))
		else $error("alternate input not pin");

	chk_pp_high: assert property (@(posedge clk) disable iff (reset)
		(dir[1] && !opt[1] && pin_data_latch[1] && !alt.out_en[1])
		|=> pin_oe[1] && pin_out[1])
		else $error("push pull high not driven");

	chk_reset_pins: assert property (@(posedge clk)
		reset |=> pin_oe == 8'h00
		&& pin_data_latch == gpxi_pkg::RST_LATCH)
		else $error("reset left pins driven");

	cov_irq: cover property (@(posedge clk) disable iff (reset)
		irq_req ##1 vector_fetch ##1 !irq_req);
	cov_od: cover property (@(posedge clk) disable iff (reset)
		|(dir & opt));
	cov_alt: cover property (@(posedge clk) disable iff (reset)
		|(alt.out_en & ~dir));

	cov_alt_in: cover property (@(posedge clk) disable iff (reset)
		|(alt.in_en & dir));

	cov_level: cover property (@(posedge clk) disable iff (reset)
		irq_req && ext_irq_edge_select == gpxi_pkg::SENS_FALL_LOW);

endmodule

// *** design/gpxi_sync.sv ***
`timescale 1ns/1ns
module gpxi_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// level
	input  wire logic async_in,
	output logic      sync_out
);

	logic stage1;
	logic next_stage1;
	logic next_sync;

	always_comb begin
		next_stage1 = async_in;
		next_sync   = stage1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			stage1   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1   <= next_stage1;
			sync_out <= next_sync;
		end
	end

endmodule

// *** tb/gpxi_pins.sv ***
`timescale 1ns/1ns
module gpxi_pins (
	// design side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	// outside drivers
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_in
);
	// ----------------------------------------
	// wire level
	// ----------------------------------------
	// released pin follows outside
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ns
module tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic                clk = 1'b0;
	logic                reset = 1'b1;
	gpxi_pkg::gpxi_cpu_t cpu = '0;
	gpxi_pkg::gpxi_alt_t alt = '0;
	logic                vector_fetch = 1'b0;
	logic [7:0]          ext_val = 8'hff;
	logic [7:0]          latch_rdata, dir_rdata, opt_rdata, alt_in;
	logic [7:0]          pin_in, pin_out, pin_oe, e_rd, e_oe, e_out;
	logic [7:0]          e_ain, msk;
	logic [1:0]          sens_rdata;
	logic                irq_req;
	int                  errors = 0;
	int                  n_checks = 0;
	int                  seed = 67037;
	int                  m_latch, m_dir, m_opt, i, m;

	always #50 clk = ~clk;

	gpxi_port i_dut (.clk(clk), .reset(reset), .cpu(cpu),
		.vector_fetch(vector_fetch), .latch_rdata(latch_rdata),
		.dir_rdata(dir_rdata), .opt_rdata(opt_rdata),
		.sens_rdata(sens_rdata), .irq_req(irq_req), .alt(alt),
		.alt_in(alt_in), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe));
	gpxi_pins i_pins (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_val(ext_val), .pin_in(pin_in));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk8(input logic [7:0] g, e, mk, input string s);
		n_checks++;
		if (((g ^ e) & mk) !== 8'h00) begin
			errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, s, g, e);
		end
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr(input logic [7:0] l, d, o);
		@(negedge clk); cpu.wr_latch = 1'b1; cpu.wdata = l;
		@(negedge clk); cpu.wr_latch = 1'b0; cpu.wr_dir = 1'b1; cpu.wdata = d;
		@(negedge clk); cpu.wr_dir = 1'b0; cpu.wr_opt = 1'b1; cpu.wdata = o;
		@(negedge clk); cpu.wr_opt = 1'b0;
		m_latch = l; m_dir = d; m_opt = o;
	endtask

	task automatic wsens(input logic [1:0] s);
		@(negedge clk); cpu.wr_sens = 1'b1; cpu.wsens = s;
		@(negedge clk); cpu.wr_sens = 1'b0;
	endtask

	task automatic expect_port;
		logic drv, v, od, lvl;
		for (int k = 0; k < 8; k++) begin
			drv = alt.out_en[k] | m_dir[k];
			v = alt.out_en[k] ? alt.out_val[k] : m_latch[k];
			od = alt.out_en[k] ? alt.open_drain[k] : m_opt[k];
			e_oe[k] = drv & !(od & v);
			e_out[k] = v;
			lvl = e_oe[k] ? v : ext_val[k];
			e_rd[k] = m_dir[k] ? m_latch[k] : (alt.out_en[k] ? v : lvl);
			e_ain[k] = m_dir[k] ? m_latch[k] : lvl;
			msk[k] = !(m_dir[k] & alt.out_en[k]);
		end
		chk8(pin_oe, e_oe, 8'hff, "oe");
		chk8(pin_out, e_out, e_oe, "out");
		chk8(latch_rdata, e_rd, msk, "read");
		chk8(alt_in, e_ain, msk, "alt_in");
		chk8(dir_rdata, m_dir[7:0], 8'hff, "dir");
		chk8(opt_rdata, m_opt[7:0], 8'hff, "opt");
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		cyc(12);
		reset = 1'b0;
		cyc(4);
		expect_port;
		chk8({6'h00, sens_rdata}, 8'h00, 8'hff, "sens");
		chk8({7'h00, irq_req}, 8'h00, 8'hff, "irq");
		$display("test reset done");
		for (i = 0; i < 40; i++) begin
			ext_val = 8'($random(seed));
			alt = $random(seed);
			alt.out_en = alt.out_en & 8'($random(seed));
			msk = ~(alt.out_en & alt.in_en);
			wr(8'($random(seed)), 8'($random(seed)) & msk,
				8'($random(seed)) & msk);
			cyc(5);
			expect_port;
		end
		$display("test random config done");
		alt = '0;
		ext_val = 8'hff;
		wr(8'h00, 8'h00, 8'hff);
		for (m = 0; m < 4; m++) begin
			wsens(2'(m));
			cyc(6);
			chk8({6'h00, sens_rdata}, 8'(m), 8'hff, "sens");
			chk8({7'h00, irq_req}, 8'h00, 8'hff, "irq idle");
			ext_val[2*m+1] = 1'b0;
			cyc(6);
			chk8({7'h00, irq_req}, 8'(m != 1), 8'hff, "irq fall");
			@(negedge clk); vector_fetch = 1'b1;
			@(negedge clk); vector_fetch = 1'b0;
			cyc(3);
			chk8({7'h00, irq_req}, 8'(m == 0), 8'hff, "irq fetch");
			ext_val[2*m+1] = 1'b1;
			cyc(6);
			chk8({7'h00, irq_req}, 8'(m != 2), 8'hff, "irq rise");
			wsens(2'(m));
			cyc(2);
			chk8({7'h00, irq_req}, 8'h00, 8'hff, "irq sens");
		end
		wr(8'h00, 8'h00, 8'h00);
		wsens(2'h3);
		ext_val = 8'h00;
		cyc(6);
		chk8({7'h00, irq_req}, 8'h00, 8'hff, "irq plain");
		$display("test interrupt done");
		print_verdict;
	end

	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		print_verdict;
	end
endmodule
